// ===== core/pwm_unit.sv
// Three PWM generators with dead-band, fault gating and an AHB-Lite slave
// What this block does
// RL1 - Down mode: count load to zero, reload
// RL2 - Up/down mode: zero to load and back
// RL3 - Direction low in down mode, follows up/down
// RL4 - One-cycle pulses at zero and at load
// RL5 - Down mode: load pulse right after zero
// RL6 - Two comparators pulse on counter match
// RL7 - Up/down: matches split by direction
// RL8 - Compare above load never matches
// RL9 - Down mode: zero, load, A down, B down
// RL10 - Up/down: six events drive outputs
// RL11 - Matches ignored on zero or load
// RL12 - Coinciding A/B: each output own match
// RL13 - Per event action: none, toggle, low, high
// RL14 - Dead-band off: raw outputs pass through
// RL15 - Dead-band on: both from first output
// RL16 - First output rising edge delayed
// RL17 - Second output inverted, rising edge delayed
// RL18 - Selected events raise an interrupt
// RL19 - Separate selection raises ADC trigger
// RL20 - Interrupt and trigger use raw events
// RL21 - Pins pair per generator 0, 1, 2
// RL22 - Counter and load are sixteen bits
// RL23 - New load/compare values apply at zero
// RL24 - Fault with fault bit forces output low
// RL25 - Dead-band delays in clocks, zero adds none
`timescale 1ns/10ps

module pwm_unit
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [pwm_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [pwm_pkg::DATA_W-1:0] hrdata,
  output logic hresp,
  // Fault pin
  input wire logic fault_in,
  // Output pins
  output logic pin_out_0,
  output logic pin_out_1,
  output logic pin_out_2,
  output logic pin_out_3,
  output logic pin_out_4,
  output logic pin_out_5,
  // Event pulses
  output logic [pwm_pkg::NGEN-1:0] gen_irq,
  output logic [pwm_pkg::NGEN-1:0] adc_trig
);
  import pwm_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    bus_e bus;
    logic [ADDR_W-1:0] addr;
    logic rdy;
    logic resp;
    logic [DATA_W-1:0] rdata;
    logic flt_s1;
    logic flt_s2;
    logic [5:0] fault_en;
    logic [NGEN-1:0][2:0] ctl;
    logic [NGEN-1:0][NEV-1:0] irq_sel;
    logic [NGEN-1:0][NEV-1:0] adc_sel;
    logic [NGEN-1:0][CNT_W-1:0] load_sw;
    logic [NGEN-1:0][CNT_W-1:0] load_act;
    logic [NGEN-1:0][CNT_W-1:0] cmpa_sw;
    logic [NGEN-1:0][CNT_W-1:0] cmpa_act;
    logic [NGEN-1:0][CNT_W-1:0] cmpb_sw;
    logic [NGEN-1:0][CNT_W-1:0] cmpb_act;
    logic [NGEN-1:0][CNT_W-1:0] cnt;
    logic [NGEN-1:0] dir;
    logic [NGEN-1:0][2*NEV-1:0] gena;
    logic [NGEN-1:0][2*NEV-1:0] genb;
    logic [NGEN-1:0][DB_W-1:0] rise_dly;
    logic [NGEN-1:0][DB_W-1:0] fall_dly;
    logic [NGEN-1:0][DB_W-1:0] rise_cnt;
    logic [NGEN-1:0][DB_W-1:0] fall_cnt;
    logic [NGEN-1:0] raw_a;
    logic [NGEN-1:0] raw_b;
    logic [2*NGEN-1:0] pins;
    logic [NGEN-1:0] irq;
    logic [NGEN-1:0] adc;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // ==========================================================
  // Helpers
  // Returns {valid, generator index} for a generator register page
  function automatic logic [2:0] gen_sel(input logic [ADDR_W-1:0] a);
    logic [1:0] idx;
    idx = 2'(a[7:6] - 2'h1);
    return {(a[11:8] == GEN_PAGE) && (a[7:6] != 2'h0), idx};
  endfunction

  // Applies the programmed action of every active event in order
  function automatic logic apply_act(input logic cur, input logic [2*NEV-1:0] cfg,
                                     input logic [NEV-1:0] ev);
    logic v;
    v = cur;
    for (int i = 0; i < NEV; i++)
    begin
      if (ev[i])
      begin
        case (act_e'(cfg[2*i +: 2])) // RL13
          ACT_TOGGLE: v = ~v;
          ACT_LOW: v = 1'b0;
          ACT_HIGH: v = 1'b1;
          default: v = v;
        endcase
      end
    end
    return v;
  endfunction

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [2:0] gs;
    logic [NEV-1:0] ev;
    logic [NEV-1:0] ev_g;
    logic [NEV-1:0] ev_a;
    logic [NEV-1:0] ev_b;
    logic en;
    logic updn;
    logic db;
    logic zero_hit;
    logic load_hit;
    logic a_hit;
    logic b_hit;
    logic down_q;
    logic o1;
    logic o2;
    logic [DATA_W-1:0] rd;
    gs = '0;
    ev = '0;
    ev_g = '0;
    ev_a = '0;
    ev_b = '0;
    en = 1'b0;
    updn = 1'b0;
    db = 1'b0;
    zero_hit = 1'b0;
    load_hit = 1'b0;
    a_hit = 1'b0;
    b_hit = 1'b0;
    down_q = 1'b0;
    o1 = 1'b0;
    o2 = 1'b0;
    rd = RDATA_RST;
    state_next = state_reg;
    state_next.resp = 1'b0;
    // Fault pin crosses in through two flops
    state_next.flt_s1 = fault_in;
    state_next.flt_s2 = state_reg.flt_s1;

    // Bus slave: writes land with zero wait, reads take one wait state
    // so that a read right after a write sees the new value.
    case (state_reg.bus)
      BUS_READ:
      begin
        gs = gen_sel(state_reg.addr);
        if (state_reg.addr == FAULT_OFS)
          rd[5:0] = state_reg.fault_en;
        else if (gs[2])
        begin
          case (state_reg.addr[5:0])
            OFS_CTL: rd[2:0] = state_reg.ctl[gs[1:0]];
            OFS_INTEN:
            begin
              rd[NEV-1:0] = state_reg.irq_sel[gs[1:0]];
              rd[INTEN_ADC_POS +: NEV] = state_reg.adc_sel[gs[1:0]];
            end
            OFS_LOAD: rd[CNT_W-1:0] = state_reg.load_sw[gs[1:0]];
            OFS_COUNT: rd[CNT_W-1:0] = state_reg.cnt[gs[1:0]];
            OFS_CMPA: rd[CNT_W-1:0] = state_reg.cmpa_sw[gs[1:0]];
            OFS_CMPB: rd[CNT_W-1:0] = state_reg.cmpb_sw[gs[1:0]];
            OFS_GENA: rd[2*NEV-1:0] = state_reg.gena[gs[1:0]];
            OFS_GENB: rd[2*NEV-1:0] = state_reg.genb[gs[1:0]];
            OFS_DBRISE: rd[DB_W-1:0] = state_reg.rise_dly[gs[1:0]];
            OFS_DBFALL: rd[DB_W-1:0] = state_reg.fall_dly[gs[1:0]];
            OFS_STATUS:
              rd[2:0] = {state_reg.raw_b[gs[1:0]], state_reg.raw_a[gs[1:0]],
                         state_reg.dir[gs[1:0]]};
            default: rd = RDATA_RST;
          endcase
        end
        state_next.rdata = rd;
        state_next.rdy = 1'b1;
        state_next.bus = BUS_IDLE;
      end
      default:
      begin
        if (state_reg.bus == BUS_WRITE)
        begin
          gs = gen_sel(state_reg.addr);
          if (state_reg.addr == FAULT_OFS)
            state_next.fault_en = hwdata[5:0];
          else if (gs[2])
          begin
            case (state_reg.addr[5:0])
              OFS_CTL: state_next.ctl[gs[1:0]] = hwdata[2:0];
              OFS_INTEN:
              begin
                state_next.irq_sel[gs[1:0]] = hwdata[NEV-1:0];
                state_next.adc_sel[gs[1:0]] = hwdata[INTEN_ADC_POS +: NEV];
              end
              OFS_LOAD: state_next.load_sw[gs[1:0]] = hwdata[CNT_W-1:0]; // RL22
              OFS_CMPA: state_next.cmpa_sw[gs[1:0]] = hwdata[CNT_W-1:0];
              OFS_CMPB: state_next.cmpb_sw[gs[1:0]] = hwdata[CNT_W-1:0];
              OFS_GENA: state_next.gena[gs[1:0]] = hwdata[2*NEV-1:0];
              OFS_GENB: state_next.genb[gs[1:0]] = hwdata[2*NEV-1:0];
              OFS_DBRISE: state_next.rise_dly[gs[1:0]] = hwdata[DB_W-1:0];
              OFS_DBFALL: state_next.fall_dly[gs[1:0]] = hwdata[DB_W-1:0];
              default: state_next.bus = BUS_IDLE;
            endcase
          end
        end
        state_next.rdy = 1'b1;
        state_next.bus = BUS_IDLE;
        if (hsel && hready && htrans[1])
        begin
          state_next.addr = haddr[ADDR_W-1:0];
          state_next.bus = hwrite ? BUS_WRITE : BUS_READ;
          state_next.rdy = hwrite;
        end
      end
    endcase

    // Generators
    for (int g = 0; g < NGEN; g++)
    begin
      en = state_reg.ctl[g][CTL_EN];
      updn = state_reg.ctl[g][CTL_UPDN];
      db = state_reg.ctl[g][CTL_DB];
      zero_hit = en && (state_reg.cnt[g] == CNT_RST); // RL4
      load_hit = en && (state_reg.cnt[g] == state_reg.load_act[g]); // RL4
      // Down mode counts as falling for match qualification
      down_q = !updn || state_reg.dir[g]; // RL7 RL9
      a_hit = en && (state_reg.cnt[g] == state_reg.cmpa_act[g])
              && (state_reg.cmpa_act[g] <= state_reg.load_act[g]); // RL6 RL8
      b_hit = en && (state_reg.cnt[g] == state_reg.cmpb_act[g])
              && (state_reg.cmpb_act[g] <= state_reg.load_act[g]); // RL6 RL8
      ev = {b_hit && down_q, b_hit && !down_q, a_hit && down_q, a_hit && !down_q,
            load_hit, zero_hit}; // RL7 RL10
      state_next.irq[g] = |(ev & state_reg.irq_sel[g]); // RL18 RL20
      state_next.adc[g] = |(ev & state_reg.adc_sel[g]); // RL19 RL20
      ev_g = ev;
      if (zero_hit || load_hit)
        ev_g[EV_BDOWN:EV_AUP] = '0; // RL11
      ev_a = ev_g;
      ev_b = ev_g;
      if ((ev_g[EV_ADOWN:EV_AUP] != '0) && (ev_g[EV_BDOWN:EV_BUP] != '0))
      begin
        ev_a[EV_BDOWN:EV_BUP] = '0; // RL12
        ev_b[EV_ADOWN:EV_AUP] = '0; // RL12
      end
      state_next.raw_a[g] = apply_act(state_reg.raw_a[g], state_reg.gena[g], ev_a);
      state_next.raw_b[g] = apply_act(state_reg.raw_b[g], state_reg.genb[g], ev_b);

      // Shadow values only switch at zero or while disabled so no runt pulses appear
      if (!en || zero_hit)
      begin
        state_next.load_act[g] = state_reg.load_sw[g]; // RL23
        state_next.cmpa_act[g] = state_reg.cmpa_sw[g]; // RL23
        state_next.cmpb_act[g] = state_reg.cmpb_sw[g]; // RL23
      end

      if (!en)
        state_next.dir[g] = 1'b0;
      else if (!updn)
      begin
        state_next.dir[g] = 1'b0; // RL3
        if (zero_hit)
          state_next.cnt[g] = state_reg.load_sw[g]; // RL1 RL5
        else
          state_next.cnt[g] = CNT_W'(state_reg.cnt[g] - 16'h0001); // RL1
      end
      else if (!state_reg.dir[g])
      begin
        if (state_reg.cnt[g] >= state_reg.load_act[g])
        begin
          state_next.dir[g] = 1'b1; // RL2 RL3
          state_next.cnt[g] = zero_hit ? CNT_RST : CNT_W'(state_reg.cnt[g] - 16'h0001);
        end
        else
          state_next.cnt[g] = CNT_W'(state_reg.cnt[g] + 16'h0001); // RL2
      end
      else if (zero_hit)
      begin
        state_next.dir[g] = 1'b0; // RL2 RL3
        state_next.cnt[g] = (state_reg.load_sw[g] == CNT_RST) ? CNT_RST : 16'h0001;
      end
      else
        state_next.cnt[g] = CNT_W'(state_reg.cnt[g] - 16'h0001); // RL2

      // Dead-band: low side drops at once, high side waits the delay
      if (!db)
      begin
        o1 = state_reg.raw_a[g]; // RL14
        o2 = state_reg.raw_b[g]; // RL14
        state_next.rise_cnt[g] = '0;
        state_next.fall_cnt[g] = '0;
      end
      else
      begin
        o1 = 1'b0;
        o2 = 1'b0;
        if (!state_reg.raw_a[g])
          state_next.rise_cnt[g] = '0;
        else if (state_reg.rise_cnt[g] >= state_reg.rise_dly[g])
          o1 = 1'b1; // RL16 RL25
        else
          state_next.rise_cnt[g] = DB_W'(state_reg.rise_cnt[g] + 16'h0001); // RL25
        if (state_reg.raw_a[g])
          state_next.fall_cnt[g] = '0; // RL15
        else if (state_reg.fall_cnt[g] >= state_reg.fall_dly[g])
          o2 = 1'b1; // RL17 RL25
        else
          state_next.fall_cnt[g] = DB_W'(state_reg.fall_cnt[g] + 16'h0001); // RL25
      end
      state_next.pins[2*g] = o1 && !(state_reg.flt_s2 && state_reg.fault_en[2*g]); // RL24
      state_next.pins[2*g+1] = o2 && !(state_reg.flt_s2 && state_reg.fault_en[2*g+1]); // RL24
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  // ==========================================================
  // Outputs
  assign hreadyout = state_reg.rdy;
  assign hrdata = state_reg.rdata;
  assign hresp = state_reg.resp;
  assign pin_out_0 = state_reg.pins[0]; // RL21
  assign pin_out_1 = state_reg.pins[1]; // RL21
  assign pin_out_2 = state_reg.pins[2]; // RL21
  assign pin_out_3 = state_reg.pins[3]; // RL21
  assign pin_out_4 = state_reg.pins[4]; // RL21
  assign pin_out_5 = state_reg.pins[5]; // RL21
  assign gen_irq = state_reg.irq;
  assign adc_trig = state_reg.adc;

  // ==========================================================
  // Checks on generator 0
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic g0_en;
  logic g0_down;
  assign g0_en = state_reg.ctl[0][CTL_EN];
  assign g0_down = g0_en && !state_reg.ctl[0][CTL_UPDN];

  property p_down_dec;
    g0_down && (state_reg.cnt[0] != CNT_RST)
      |=> state_reg.cnt[0] == CNT_W'($past(state_reg.cnt[0]) - 16'h0001);
  endproperty
  a_down_dec: assert property (p_down_dec) else $error("down count did not step"); // RL1

  property p_down_reload;
    g0_down && (state_reg.cnt[0] == CNT_RST) ##1 g0_down
      |-> state_reg.cnt[0] == $past(state_reg.load_sw[0]);
  endproperty
  a_down_reload: assert property (p_down_reload) else $error("no reload after zero"); // RL5

  property p_dir_low;
    g0_down |=> !state_reg.dir[0];
  endproperty
  a_dir_low: assert property (p_dir_low) else $error("direction high in down mode"); // RL3

  property p_up_inc;
    g0_en && state_reg.ctl[0][CTL_UPDN] && !state_reg.dir[0]
      && (state_reg.cnt[0] < state_reg.load_act[0])
      |=> state_reg.cnt[0] == CNT_W'($past(state_reg.cnt[0]) + 16'h0001);
  endproperty
  a_up_inc: assert property (p_up_inc) else $error("up count did not step"); // RL2

  property p_irq_zero;
    g0_en && (state_reg.cnt[0] == CNT_RST) && state_reg.irq_sel[0][EV_ZERO] |=> gen_irq[0];
  endproperty
  a_irq_zero: assert property (p_irq_zero) else $error("zero event lost irq"); // RL18

  property p_adc_none;
    (state_reg.adc_sel[0] == '0) |=> !adc_trig[0];
  endproperty
  a_adc_none: assert property (p_adc_none) else $error("trigger without selection"); // RL19

  property p_bypass;
    !state_reg.ctl[0][CTL_DB] && (state_reg.fault_en[1:0] == 2'b00)
      |=> (pin_out_0 == $past(state_reg.raw_a[0])) && (pin_out_1 == $past(state_reg.raw_b[0]));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass altered outputs"); // RL14

  property p_fault;
    state_reg.flt_s2 && state_reg.fault_en[0] |=> !pin_out_0;
  endproperty
  a_fault: assert property (p_fault) else $error("fault did not force low"); // RL24

  property p_db_pair;
    state_reg.ctl[0][CTL_DB] |=> !(pin_out_0 && pin_out_1);
  endproperty
  a_db_pair: assert property (p_db_pair) else $error("dead-band pair overlap"); // RL15

  property p_db_rise0;
    state_reg.ctl[0][CTL_DB] && (state_reg.rise_dly[0] == '0) && state_reg.raw_a[0]
      && !state_reg.fault_en[0] |=> pin_out_0;
  endproperty
  a_db_rise0: assert property (p_db_rise0) else $error("zero delay added delay"); // RL25

  property p_toggle_zero;
    g0_en && (state_reg.cnt[0] == CNT_RST) && (state_reg.load_act[0] != CNT_RST)
      && (state_reg.gena[0][1:0] == 2'b01) && (state_reg.gena[0][3:2] == 2'b00)
      |=> state_reg.raw_a[0] != $past(state_reg.raw_a[0]);
  endproperty
  a_toggle_zero: assert property (p_toggle_zero) else $error("toggle on zero missed"); // RL13

  c_down_zero: cover property (g0_down && state_reg.cnt[0] == CNT_RST ##1 g0_down);
  c_dir_flip: cover property (!state_reg.dir[0] ##1 state_reg.dir[0]);
  c_db_run: cover property (state_reg.ctl[0][CTL_DB] && pin_out_0 ##[1:50] pin_out_1);
  c_fault: cover property (state_reg.flt_s2 && state_reg.fault_en != '0);

endmodule // pwm_unit

// ===== core/pwm_pkg.sv
// Constants, register map and types for the PWM generator block
package pwm_pkg;

  // ==========================================================
  // Widths and counts
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int CNT_W = 16;
  localparam int DB_W = 16;
  localparam int NGEN = 3;
  localparam int NEV = 6;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [11:0] FAULT_OFS = 12'h010;
  localparam logic [3:0] GEN_PAGE = 4'h0;
  localparam logic [5:0] OFS_CTL = 6'h00;
  localparam logic [5:0] OFS_INTEN = 6'h04;
  localparam logic [5:0] OFS_LOAD = 6'h10;
  localparam logic [5:0] OFS_COUNT = 6'h14;
  localparam logic [5:0] OFS_CMPA = 6'h18;
  localparam logic [5:0] OFS_CMPB = 6'h1C;
  localparam logic [5:0] OFS_GENA = 6'h20;
  localparam logic [5:0] OFS_GENB = 6'h24;
  localparam logic [5:0] OFS_DBRISE = 6'h2C;
  localparam logic [5:0] OFS_DBFALL = 6'h30;
  localparam logic [5:0] OFS_STATUS = 6'h34;

  // ==========================================================
  // Field positions
  localparam int CTL_EN = 0;
  localparam int CTL_UPDN = 1;
  localparam int CTL_DB = 2;
  localparam int INTEN_ADC_POS = 8;
  localparam int EV_ZERO = 0;
  localparam int EV_LOAD = 1;
  localparam int EV_AUP = 2;
  localparam int EV_ADOWN = 3;
  localparam int EV_BUP = 4;
  localparam int EV_BDOWN = 5;

  // ==========================================================
  // Reset values
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_LOW = 2'b10,
    ACT_HIGH = 2'b11
  } act_e;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ = 2'b10
  } bus_e;

endpackage

// ===== sim/pwm_bridge_model.sv
// Half-bridge gate driver model: shoot-through monitor and fault trip
`timescale 1ns/10ps

module pwm_bridge_model
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Gate inputs and bench trip request
  input wire logic [5:0] gate,
  input wire logic trip,
  // Fault line and overlap count
  output logic fault_out,
  output logic [15:0] overlap
);
  // ==========================================================
  // Trip line and shoot-through counter
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_out <= 1'b0;
      overlap <= 16'h0000;
    end
    else
    begin
      // Overcurrent comparator, one flop late like a real driver
      fault_out <= trip;
      if ((gate[0] & gate[1]) | (gate[2] & gate[3]) | (gate[4] & gate[5]))
        overlap <= overlap + 16'h0001;
    end
  end
endmodule // pwm_bridge_model

// ===== sim/test_pwm_generator_deadband.sv
// Self-checking bench for the PWM unit against a cycle model of a generator
`timescale 1ns/10ps

module test_pwm_generator_deadband;
  import pwm_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [DATA_W-1:0] hwdata = 32'h0000_0000;
  logic [DATA_W-1:0] hrdata;
  logic hreadyout, hresp, fault_in;
  logic trip = 1'b0;
  logic [5:0] pins;
  logic [NGEN-1:0] gen_irq, adc_trig;
  logic [15:0] overlap;
  logic [31:0] rng = 32'hE71598A9;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;

  // ==========================================================
  // Clock, design and bridge
  initial
    forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    cyc++;

  pwm_unit dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .fault_in(fault_in),
    .pin_out_0(pins[0]), .pin_out_1(pins[1]), .pin_out_2(pins[2]), .pin_out_3(pins[3]),
    .pin_out_4(pins[4]), .pin_out_5(pins[5]), .gen_irq(gen_irq), .adc_trig(adc_trig));

  pwm_bridge_model bridge_u (.sys_clk(sys_clk), .rst_n(rst_n), .gate(pins), .trip(trip),
    .fault_out(fault_in), .overlap(overlap));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function automatic logic [11:0] ga(input int g, input logic [5:0] o);
    return 12'(64 * (g + 1)) + {6'h00, o};
  endfunction

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (exp !== got)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
      chk("hready", 1, 0);
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h00000, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    chk("hresp", 0, hresp);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk("read", exp, q);
  endtask

  task automatic reset_dut();
    rst_n <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
  endtask

  // Leaves the sampling point one negedge after the pulse edge
  task automatic waitp(input int g);
    int n;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (adc_trig[g] !== 1'b1 && n < 200);
    if (adc_trig[g] !== 1'b1)
      chk("trigger", 1, 0);
  endtask

  // ==========================================================
  // Generator model
  function automatic logic [5:0] evs(int c, int l, int a, int b, logic dn, logic ud);
    logic [5:0] e;
    e = 6'h00;
    e[EV_ZERO] = (c == 0);
    e[EV_LOAD] = (c == l);
    e[EV_AUP] = (c == a) && ud && !dn;
    e[EV_ADOWN] = (c == a) && (dn || !ud);
    e[EV_BUP] = (c == b) && ud && !dn;
    e[EV_BDOWN] = (c == b) && (dn || !ud);
    return e;
  endfunction

  // Other pair's matches dropped only when A and B coincide; all dropped on zero or load
  function automatic logic act(logic v, logic [5:0] e, logic [11:0] cfg, int own);
    logic [5:0] m;
    m = e;
    if (e[EV_ZERO] || e[EV_LOAD])
      m = e & 6'h03;
    else if ((e[EV_ADOWN:EV_AUP] != 2'b00) && (e[EV_BDOWN:EV_BUP] != 2'b00))
      m = e & (6'h03 | (6'h03 << own));
    for (int i = 0; i < NEV; i++)
      if (m[i])
        case (act_e'(cfg[2*i +: 2]))
          ACT_TOGGLE: v = ~v;
          ACT_LOW: v = 1'b0;
          ACT_HIGH: v = 1'b1;
          default: ;
        endcase
    return v;
  endfunction

  task automatic run(int g, logic ud, logic db, int l, int a, int b, logic [11:0] cga,
    logic [11:0] cgb, logic [5:0] isel, logic [5:0] asel, int r, int f);
    int c;
    logic dn, ra, rb, pe, po;
    logic [31:0] hist, mr, mf;
    logic [5:0] e, expp;
    reset_dut();
    wr(ga(g, OFS_LOAD), l);
    wr(ga(g, OFS_CMPA), a);
    wr(ga(g, OFS_CMPB), b);
    wr(ga(g, OFS_GENA), cga);
    wr(ga(g, OFS_GENB), cgb);
    wr(ga(g, OFS_DBRISE), r);
    wr(ga(g, OFS_DBFALL), f);
    wr(ga(g, OFS_INTEN), (32'(asel) << INTEN_ADC_POS) | 32'(isel));
    wr(ga(g, OFS_CTL), 32'(1 << CTL_EN) | (32'(ud) << CTL_UPDN) | (32'(db) << CTL_DB));
    waitp(g);
    {c, dn, ra, rb, pe, po, hist} = '0;
    mr = (32'h1 << (r + 1)) - 1;
    mf = (32'h1 << (f + 1)) - 1;
    for (int j = 0; j < 130; j++)
    begin
      e = evs(c, l, a, b, dn, ud);
      chk("irq", |(e & isel), gen_irq[g]);
      chk("adc", |(e & asel), adc_trig[g]);
      expp = 6'h00;
      expp[2*g] = pe;
      expp[2*g+1] = po;
      if (!db || j > 12)
        chk("pins", expp, pins);
      ra = act(ra, e, cga, EV_AUP);
      rb = act(rb, e, cgb, EV_BUP);
      hist = {hist[30:0], ra};
      pe = db ? ((hist & mr) == mr) : ra;
      po = db ? ((hist & mf) == 0) : rb;
      if (!ud)
        c = (c == 0) ? l : c - 1;
      else if (c == l && !dn)
        {dn, c} = {1'b1, 32'(l - 1)};
      else if (c == 0 && dn)
        {dn, c} = {1'b0, 32'd1};
      else
        c = dn ? c - 1 : c + 1;
      @(negedge sys_clk);
    end
    if (db)
      chk("overlap", 0, overlap);
  endtask

  // ==========================================================
  // Scenarios
  initial
  begin
    logic [5:0] ofs [11] = '{OFS_CTL, OFS_INTEN, OFS_LOAD, OFS_COUNT, OFS_CMPA, OFS_CMPB,
      OFS_GENA, OFS_GENB, OFS_DBRISE, OFS_DBFALL, OFS_STATUS};
    int l, a, b, t0, t1;
    logic ud;
    reset_dut();
    for (int g = 0; g < NGEN; g++)
      for (int k = 0; k < 11; k++)
        rchk(ga(g, ofs[k]), 32'h0);
    rchk(FAULT_OFS, 32'h0);
    wr(12'h100, 32'hFFFF_FFFF);
    rchk(12'h100, 32'h0);
    wr(ga(0, OFS_LOAD), 32'hFFFF_FFFF);
    rchk(ga(0, OFS_LOAD), 32'h0000_FFFF);
    wr(ga(0, OFS_COUNT), 32'h0000_1234);
    rchk(ga(0, OFS_COUNT), 32'h0);
    for (int it = 0; it < 9; it++)
    begin
      ud = rnd() % 2;
      l = 4 + rnd() % 17;
      a = ud ? 1 + rnd() % (l - 1) : rnd() % (l + 3);
      b = ud ? 1 + rnd() % (l - 1) : rnd() % (l + 1);
      if (rnd() % 4 == 0)
        b = a;
      run(it % 3, ud, rnd() % 2, l, a, b, rnd(), rnd(), rnd(), rnd() | 1, rnd() % 8,
        rnd() % 8);
    end
    // Load change mid-period must wait for the next zero
    reset_dut();
    wr(ga(1, OFS_LOAD), 40);
    wr(ga(1, OFS_INTEN), 32'(1) << INTEN_ADC_POS);
    wr(ga(1, OFS_CTL), 32'h3);
    waitp(1);
    t0 = cyc;
    repeat (30) @(posedge sys_clk);
    wr(ga(1, OFS_LOAD), 10);
    waitp(1);
    t1 = cyc;
    chk("period old", 80, t1 - t0);
    waitp(1);
    chk("period new", 20, cyc - t1);
    // Fault gating on pin 0 only
    reset_dut();
    wr(FAULT_OFS, 32'h1);
    wr(ga(0, OFS_LOAD), 9);
    wr(ga(0, OFS_GENA), 32'h3);
    wr(ga(0, OFS_GENB), 32'h3);
    wr(ga(0, OFS_CTL), 32'h1);
    repeat (10) @(negedge sys_clk);
    chk("pins run", 2'b11, pins[1:0]);
    @(posedge sys_clk);
    trip <= 1'b1;
    repeat (8) @(negedge sys_clk);
    chk("pins fault", 2'b10, pins[1:0]);
    @(posedge sys_clk);
    trip <= 1'b0;
    repeat (8) @(negedge sys_clk);
    chk("pins clear", 2'b11, pins[1:0]);
    conclude();
  end

  initial
  begin
    #400000;
    bad_count++;
    conclude();
  end
endmodule // test_pwm_generator_deadband
